//--- verilog/sram_link_pkg.sv
package sram_link_pkg;

    typedef enum logic [1:0] {
        WIDTH_SINGLE,
        WIDTH_DUAL,
        WIDTH_QUAD
    } bus_width_t;

    localparam logic [7:0] ENTER_DUAL_CMD = 8'h3b;
    localparam logic [7:0] ENTER_QUAD_CMD = 8'h38;
    localparam logic [7:0] REVERT_SINGLE_LINE_CMD = 8'hff;
    localparam int PAUSE_LANE = 3;
    localparam int MCLK_PERIOD_NS = 10;
    localparam int SCK_PERIOD_NS = 120;
    localparam int SCK_HALF_CYCLES = SCK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
    localparam logic [3:0] DEV_MASK_SINGLE = 4'h2;
    localparam logic [3:0] DEV_MASK_DUAL = 4'h3;
    localparam logic [3:0] HOST_MASK_SINGLE = 4'h9;
    localparam logic [3:0] HOST_MASK_DUAL_WR = 4'hb;
    localparam logic [3:0] HOST_MASK_DUAL_RD = 4'h8;
    localparam logic [3:0] MASK_ALL = 4'hf;
    localparam logic [3:0] MASK_NONE = 4'h0;

    function automatic logic [2:0] step_of(input bus_width_t w);
        case (w)
            WIDTH_DUAL: step_of = 3'h2;
            WIDTH_QUAD: step_of = 3'h4;
            default: step_of = 3'h1;
        endcase
    endfunction

    function automatic bus_width_t next_width(input bus_width_t w, input logic [7:0] cmd);
        next_width = w;
        if (cmd == REVERT_SINGLE_LINE_CMD) begin
            next_width = WIDTH_SINGLE;
        end else if (w == WIDTH_SINGLE && cmd == ENTER_DUAL_CMD) begin
            next_width = WIDTH_DUAL;
        end else if (w == WIDTH_SINGLE && cmd == ENTER_QUAD_CMD) begin
            next_width = WIDTH_QUAD;
        end
    endfunction

    function automatic logic [3:0] out_bits(input logic [7:0] b, input bus_width_t w);
        case (w)
            WIDTH_DUAL: out_bits = {2'b00, b[7:6]};
            WIDTH_QUAD: out_bits = b[7:4];
            default: out_bits = {2'b00, b[7], b[7]};
        endcase
    endfunction

    function automatic logic [7:0] in_merge(input logic [7:0] sh, input logic [3:0] ln,
                                            input bus_width_t w, input logic so_side);
        case (w)
            WIDTH_DUAL: in_merge = {sh[5:0], ln[1:0]};
            WIDTH_QUAD: in_merge = {sh[3:0], ln[3:0]};
            default: in_merge = {sh[6:0], so_side ? ln[1] : ln[0]};
        endcase
    endfunction

endpackage

//--- verilog/sram_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sram_link_if;
    logic cs_n;
    logic sck;
    logic [3:0] h_out;
    logic [3:0] h_oe;
    logic [3:0] d_out;
    logic [3:0] d_oe;
    logic [3:0] lane;

    // Resolved lane levels; an undriven lane is pulled high.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lane[i] = d_oe[i] ? d_out[i] : (h_oe[i] ? h_out[i] : 1'b1);
        end
    end

    modport host_end(output cs_n, output sck, output h_out, output h_oe, input lane);
    modport device_end(input cs_n, input sck, input lane, output d_out, output d_oe);
endinterface
`default_nettype wire

//--- verilog/sram_link_host.sv
`timescale 1ns/1ps
`default_nettype none
module sram_link_host
    import sram_link_pkg::*;
(
    // System
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // Link
    sram_link_if.host_end link,
    // Byte requests
    input wire logic req_in,
    input wire logic [7:0] req_byte_in,
    input wire logic req_read_in,
    input wire logic req_last_in,
    input wire logic pause_in,
    output logic ready_out,
    output logic done_out,
    output logic [7:0] rx_byte_out,
    output var bus_width_t width_out
);

    typedef enum logic [2:0] {H_BOOT, H_IDLE, H_LOW, H_HIGH, H_GAP} host_state_t;

    host_state_t state_q;
    bus_width_t width_q;
    logic [7:0] div_q;
    logic [2:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] cmd_q;
    logic [7:0] rx_q;
    logic [3:0] lanes_q;
    logic [3:0] lane_s1_q;
    logic [3:0] lane_s2_q;
    logic [1:0] boot_q;
    logic cs_n_q;
    logic sck_q;
    logic pause_q;
    logic read_q;
    logic last_q;
    logic first_q;
    logic done_q;
    logic [7:0] shifted;
    logic [2:0] cnt_next;
    logic [3:0] mask;
    logic half_end;

    // ------------------------------------------------------------
    // Lane synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lane_s1_q <= 4'h0;
            lane_s2_q <= 4'h0;
        end else if (ce_in) begin
            lane_s1_q <= link.lane;
            lane_s2_q <= lane_s1_q;
        end
    end

    assign shifted = sh_q << step_of(width_q);
    assign cnt_next = cnt_q + step_of(width_q);
    assign half_end = (div_q == 8'(SCK_HALF_CYCLES - 1));

    // ------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= H_BOOT;
            width_q <= WIDTH_QUAD;
            div_q <= 8'h00;
            cnt_q <= 3'h0;
            sh_q <= 8'h00;
            cmd_q <= 8'h00;
            rx_q <= 8'h00;
            lanes_q <= 4'hf;
            boot_q <= 2'h0;
            cs_n_q <= 1'b1;
            sck_q <= 1'b0;
            pause_q <= 1'b0;
            read_q <= 1'b0;
            last_q <= 1'b0;
            first_q <= 1'b1;
            done_q <= 1'b0;
            rx_byte_out <= 8'h00;
        end else if (ce_in) begin
            done_q <= 1'b0;
            case (state_q)
                H_BOOT: begin
                    cs_n_q <= 1'b0;
                    sh_q <= REVERT_SINGLE_LINE_CMD;
                    lanes_q <= out_bits(REVERT_SINGLE_LINE_CMD, width_q);
                    read_q <= 1'b0;
                    last_q <= 1'b1;
                    div_q <= 8'h00;
                    state_q <= H_LOW;
                end
                H_IDLE: begin
                    if (req_in) begin
                        cs_n_q <= 1'b0;
                        sh_q <= req_byte_in;
                        cmd_q <= req_byte_in;
                        lanes_q <= out_bits(req_byte_in, width_q);
                        read_q <= req_read_in;
                        last_q <= req_last_in;
                        div_q <= 8'h00;
                        state_q <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (pause_in && width_q != WIDTH_QUAD && boot_q == 2'h2) begin
                        pause_q <= 1'b1;
                        div_q <= 8'h00;
                    end else if (pause_q) begin
                        pause_q <= 1'b0;
                    end else if (half_end) begin
                        sck_q <= 1'b1;
                        rx_q <= in_merge(rx_q, lane_s2_q, width_q, 1'b1);
                        div_q <= 8'h00;
                        state_q <= H_HIGH;
                    end else begin
                        div_q <= div_q + 8'h01;
                    end
                end
                H_HIGH: begin
                    if (half_end) begin
                        sck_q <= 1'b0;
                        div_q <= 8'h00;
                        cnt_q <= cnt_next;
                        if (cnt_next == 3'h0) begin
                            done_q <= (boot_q == 2'h2);
                            rx_byte_out <= rx_q;
                            first_q <= 1'b0;
                            if (boot_q != 2'h2) begin
                                width_q <= (boot_q == 2'h0) ? WIDTH_DUAL : WIDTH_SINGLE;
                                boot_q <= boot_q + 2'h1;
                            end else if (first_q) begin
                                width_q <= next_width(width_q, cmd_q);
                            end
                            if (last_q) begin
                                cs_n_q <= 1'b1;
                                state_q <= H_GAP;
                            end else begin
                                state_q <= H_IDLE;
                            end
                        end else begin
                            sh_q <= shifted;
                            lanes_q <= out_bits(shifted, width_q);
                            state_q <= H_LOW;
                        end
                    end else begin
                        div_q <= div_q + 8'h01;
                    end
                end
                default: begin
                    first_q <= 1'b1;
                    if (half_end) begin
                        div_q <= 8'h00;
                        state_q <= (boot_q == 2'h2) ? H_IDLE : H_BOOT;
                    end else begin
                        div_q <= div_q + 8'h01;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always_comb begin
        case (width_q)
            WIDTH_QUAD: mask = read_q ? MASK_NONE : MASK_ALL;
            WIDTH_DUAL: mask = read_q ? HOST_MASK_DUAL_RD : HOST_MASK_DUAL_WR;
            default: mask = HOST_MASK_SINGLE;
        endcase
    end

    assign link.cs_n = cs_n_q;
    assign link.sck = sck_q;
    assign link.h_oe = mask;
    assign link.h_out = {(width_q == WIDTH_QUAD) ? lanes_q[3] : ~pause_q, lanes_q[2:0]};
    assign ready_out = (state_q == H_IDLE);
    assign done_out = done_q;
    assign width_out = width_q;

endmodule
`default_nettype wire

//--- verilog/sram_link_device.sv
`timescale 1ns/1ps
`default_nettype none
module sram_link_device
    import sram_link_pkg::*;
(
    // System
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // Link
    sram_link_if.device_end link,
    // Answer data
    input wire logic [7:0] tx_byte_in,
    input wire logic tx_load_in,
    input wire logic respond_in,
    // Received data and status
    output logic [7:0] rx_byte_out,
    output logic rx_valid_out,
    output logic [7:0] cmd_out,
    output var bus_width_t width_out
);

    bus_width_t width_q;
    bus_width_t width_s1_q;
    bus_width_t width_s2_q;
    logic sel_rst_n;
    logic hold_now;
    logic [2:0] step;
    logic [7:0] merged;
    logic [2:0] cnt_next;
    logic byte_done;
    logic [2:0] cnt_q;
    logic [7:0] rx_sh_q;
    logic [7:0] rx_byte_q;
    logic [7:0] cmd_q;
    logic rx_tgl_q;
    logic cmd_phase_q;
    logic out_phase_q;
    logic resp_q;
    logic resp_s1_q;
    logic resp_s2_q;
    logic [7:0] tx_hold_q;
    logic tx_tgl_q;
    logic tx_tgl_s1_q;
    logic tx_tgl_s2_q;
    logic tx_tgl_s3_q;
    logic [7:0] tx_byte_q;
    logic drive_q;
    logic [2:0] ocnt_q;
    logic [7:0] tx_sh_q;
    logic [7:0] tx_src;
    logic [3:0] lanes_q;
    logic [3:0] mask;
    logic rx_tgl_s1_q;
    logic rx_tgl_s2_q;
    logic rx_tgl_s3_q;

    // ------------------------------------------------------------
    // Link-side decode
    // ------------------------------------------------------------
    assign sel_rst_n = rst_n_in & ~link.cs_n;
    assign hold_now = (width_q != WIDTH_QUAD) & ~link.lane[PAUSE_LANE];
    assign step = step_of(width_q);
    assign merged = in_merge(rx_sh_q, link.lane, width_q, 1'b0);
    assign cnt_next = cnt_q + step;
    assign byte_done = (cnt_next == 3'h0);

    // ------------------------------------------------------------
    // Capture on the rising edge
    // ------------------------------------------------------------
    always_ff @(posedge link.sck or negedge sel_rst_n) begin
        if (!sel_rst_n) begin
            cnt_q <= 3'h0;
            rx_sh_q <= 8'h00;
            cmd_phase_q <= 1'b1;
            out_phase_q <= 1'b0;
        end else if (!hold_now) begin
            rx_sh_q <= merged;
            cnt_q <= cnt_next;
            if (byte_done) begin
                cmd_phase_q <= 1'b0;
                if (cmd_phase_q && resp_s2_q) begin
                    out_phase_q <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge link.sck or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_byte_q <= 8'h00;
            cmd_q <= 8'h00;
            rx_tgl_q <= 1'b0;
        end else if (!link.cs_n && !hold_now && byte_done) begin
            rx_byte_q <= merged;
            rx_tgl_q <= ~rx_tgl_q;
            if (cmd_phase_q) begin
                cmd_q <= merged;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus width
    // ------------------------------------------------------------
    always_ff @(posedge link.sck or negedge rst_n_in) begin
        if (!rst_n_in) begin
            width_q <= WIDTH_SINGLE;
        end else if (!link.cs_n && !hold_now && byte_done && cmd_phase_q) begin
            width_q <= next_width(width_q, merged);
        end
    end

    // ------------------------------------------------------------
    // Crossings into the link domain
    // ------------------------------------------------------------
    always_ff @(posedge link.sck or negedge rst_n_in) begin
        if (!rst_n_in) begin
            resp_s1_q <= 1'b0;
            resp_s2_q <= 1'b0;
            tx_tgl_s1_q <= 1'b0;
            tx_tgl_s2_q <= 1'b0;
            tx_tgl_s3_q <= 1'b0;
        end else begin
            resp_s1_q <= resp_q;
            resp_s2_q <= resp_s1_q;
            tx_tgl_s1_q <= tx_tgl_q;
            tx_tgl_s2_q <= tx_tgl_s1_q;
            tx_tgl_s3_q <= tx_tgl_s2_q;
        end
    end

    always_ff @(posedge link.sck or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_byte_q <= 8'h00;
        end else if (tx_tgl_s2_q != tx_tgl_s3_q) begin
            tx_byte_q <= tx_hold_q;
        end
    end

    // ------------------------------------------------------------
    // Drive on the falling edge
    // ------------------------------------------------------------
    assign tx_src = (ocnt_q == 3'h0) ? tx_byte_q : tx_sh_q;

    always_ff @(negedge link.sck or negedge sel_rst_n) begin
        if (!sel_rst_n) begin
            drive_q <= 1'b0;
            ocnt_q <= 3'h0;
            tx_sh_q <= 8'h00;
            lanes_q <= 4'h0;
        end else if (!hold_now && out_phase_q) begin
            drive_q <= 1'b1;
            lanes_q <= out_bits(tx_src, width_q);
            tx_sh_q <= tx_src << step;
            ocnt_q <= ocnt_q + step;
        end
    end

    always_comb begin
        case (width_q)
            WIDTH_QUAD: mask = MASK_ALL;
            WIDTH_DUAL: mask = DEV_MASK_DUAL;
            default: mask = DEV_MASK_SINGLE;
        endcase
    end

    assign link.d_out = lanes_q;
    assign link.d_oe = {drive_q & (width_q == WIDTH_QUAD),
                        mask[2:0] & {3{drive_q & ~hold_now}}};

    // ------------------------------------------------------------
    // User side
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_hold_q <= 8'h00;
            tx_tgl_q <= 1'b0;
            resp_q <= 1'b0;
        end else if (ce_in) begin
            resp_q <= respond_in;
            if (tx_load_in) begin
                tx_hold_q <= tx_byte_in;
                tx_tgl_q <= ~tx_tgl_q;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_tgl_s1_q <= 1'b0;
            rx_tgl_s2_q <= 1'b0;
            rx_tgl_s3_q <= 1'b0;
            width_s1_q <= WIDTH_SINGLE;
            width_s2_q <= WIDTH_SINGLE;
        end else if (ce_in) begin
            rx_tgl_s1_q <= rx_tgl_q;
            rx_tgl_s2_q <= rx_tgl_s1_q;
            rx_tgl_s3_q <= rx_tgl_s2_q;
            width_s1_q <= width_q;
            width_s2_q <= width_s1_q;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_byte_out <= 8'h00;
            cmd_out <= 8'h00;
            rx_valid_out <= 1'b0;
        end else if (ce_in) begin
            rx_valid_out <= rx_tgl_s2_q ^ rx_tgl_s3_q;
            if (rx_tgl_s2_q ^ rx_tgl_s3_q) begin
                rx_byte_out <= rx_byte_q;
                cmd_out <= cmd_q;
            end
        end
    end

    assign width_out = width_s2_q;

endmodule
`default_nettype wire

//--- test/serial_sram_bus_mode_and_pause_props.sv
`timescale 1ns/1ps
`default_nettype none
module serial_sram_bus_mode_and_pause_props
    import sram_link_pkg::*;
(
    // System
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Link
    input wire logic cs_n,
    input wire logic sck,
    input wire logic [3:0] d_out,
    input wire logic [3:0] d_oe,
    input wire logic [3:0] lane,
    input var bus_width_t width_out
);
    // ------------------------------------------------------------
    // Link properties.
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    logic sw;
    logic dw;
    logic qw;
    assign sw = (width_out == WIDTH_SINGLE);
    assign dw = (width_out == WIDTH_DUAL);
    assign qw = (width_out == WIDTH_QUAD);

    property p_float;
        sw && !lane[3] |-> d_oe[2:0] == 3'h0;
    endproperty
    a_float: assert property (p_float) else $error("Output driven while paused.");
    property p_pause_sel;
        sw && !lane[3] |-> !cs_n;
    endproperty
    a_pause_sel: assert property (p_pause_sel) else $error("Pause outside selection.");
    property p_pause_fall;
        sw && $fell(lane[3]) |-> !sck;
    endproperty
    a_pause_fall: assert property (p_pause_fall) else $error("Pause lowered with clock high.");
    property p_pause_rise;
        sw && $rose(lane[3]) |-> !sck;
    endproperty
    a_pause_rise: assert property (p_pause_rise) else $error("Pause raised with clock high.");
    property p_frozen;
        sw && !lane[3] && $past(!lane[3]) |-> $stable(d_out);
    endproperty
    a_frozen: assert property (p_frozen) else $error("Output moved while paused.");
    property p_out_fall;
        !cs_n && $past(!cs_n) && $changed(d_out) |-> $fell(sck);
    endproperty
    a_out_fall: assert property (p_out_fall) else $error("Output changed off a clock fall.");
    property p_dual;
        dw && $past(dw) |-> d_oe[3:2] == 2'b00 && d_oe[1] == d_oe[0];
    endproperty
    a_dual: assert property (p_dual) else $error("Dual lanes not paired.");
    property p_quad;
        qw && $past(qw) |-> d_oe == MASK_ALL || d_oe == MASK_NONE;
    endproperty
    a_quad: assert property (p_quad) else $error("Quad lanes not all driven.");
    property p_single;
        sw && $past(sw) |-> (d_oe & ~DEV_MASK_SINGLE) == MASK_NONE;
    endproperty
    a_single: assert property (p_single) else $error("Pause pin driven in single.");
    property p_boot;
        $rose(rst_n_in) |-> sw;
    endproperty
    a_boot: assert property (p_boot) else $error("Not single after reset.");
    c_quad: cover property (qw && !cs_n);
    c_dual: cover property (dw && !cs_n);
    c_pause: cover property (sw && $fell(lane[3]));
endmodule
`default_nettype wire

//--- test/tb_serial_sram_bus_mode_and_pause.sv
`timescale 1ns/1ps
`default_nettype none
module tb_serial_sram_bus_mode_and_pause;
    import sram_link_pkg::*;
    logic mclk_in = 1'b0;
    logic host_rst_n = 1'b0;
    logic dev_rst_n = 1'b0;
    logic req_in = 1'b0;
    logic [7:0] req_byte_in = 8'h00;
    logic req_read_in = 1'b0;
    logic req_last_in = 1'b0;
    logic pause_in = 1'b0;
    logic [7:0] tx_byte_in = 8'h00;
    logic tx_load_in = 1'b0;
    logic respond_in = 1'b0;
    logic ready_out, done_out, rx_valid_out;
    logic [7:0] h_rx, d_rx, cmd_out;
    bus_width_t h_width, d_width;
    bus_width_t w_exp = WIDTH_SINGLE;
    int n_mismatch = 0;
    int num_checks = 0;
    int seed = 32'h3257;
    logic [7:0] rxq[$];
    logic [7:0] cmds[6] = '{8'h3b, 8'h38, 8'hff, 8'h38, 8'h3b, 8'hff};

    sram_link_if link();
    sram_link_host i_sram_link_host(.mclk_in(mclk_in), .rst_n_in(host_rst_n), .ce_in(1'b1),
        .link(link), .req_in(req_in), .req_byte_in(req_byte_in), .req_read_in(req_read_in),
        .req_last_in(req_last_in), .pause_in(pause_in), .ready_out(ready_out),
        .done_out(done_out), .rx_byte_out(h_rx), .width_out(h_width));
    sram_link_device i_sram_link_device(.mclk_in(mclk_in), .rst_n_in(dev_rst_n), .ce_in(1'b1),
        .link(link), .tx_byte_in(tx_byte_in), .tx_load_in(tx_load_in), .respond_in(respond_in),
        .rx_byte_out(d_rx), .rx_valid_out(rx_valid_out), .cmd_out(cmd_out),
        .width_out(d_width));
    serial_sram_bus_mode_and_pause_props i_props(.mclk_in(mclk_in), .rst_n_in(dev_rst_n),
        .cs_n(link.cs_n), .sck(link.sck), .d_out(link.d_out), .d_oe(link.d_oe),
        .lane(link.lane), .width_out(d_width));

    // ------------------------------------------------------------
    // Checking and expectation helpers.
    // ------------------------------------------------------------
    initial forever #5 mclk_in = ~mclk_in;
    always @(negedge mclk_in) if (rx_valid_out === 1'b1) rxq.push_back(d_rx);

    task automatic conclude();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        n_mismatch++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) fail($sformatf("byte %h, expected %h", got, exp));
    endtask
    task automatic cmp_width(input bus_width_t got, input bus_width_t exp);
        num_checks++;
        if (got !== exp) fail($sformatf("width %0d, expected %0d", got, exp));
    endtask
    task automatic cmp_count(input int got, input int exp);
        num_checks++;
        if (got != exp) fail($sformatf("count %0d, expected %0d", got, exp));
    endtask
    function automatic bus_width_t nxt(input bus_width_t w, input logic [7:0] c);
        if (c == 8'hff) return WIDTH_SINGLE;
        if (w == WIDTH_SINGLE && c == 8'h3b) return WIDTH_DUAL;
        if (w == WIDTH_SINGLE && c == 8'h38) return WIDTH_QUAD;
        return w;
    endfunction
    function automatic int lat(input bus_width_t w);
        return (8 / (w == WIDTH_QUAD ? 4 : (w == WIDTH_DUAL ? 2 : 1))) * 2 * SCK_HALF_CYCLES;
    endfunction
    function automatic logic [7:0] safe(input logic [7:0] b);
        return (b == 8'hff || b == 8'h3b || b == 8'h38) ? 8'h02 : b;
    endfunction

    // ------------------------------------------------------------
    // Transfer tasks.
    // ------------------------------------------------------------
    task automatic wait_ready();
        int i;
        i = 0;
        while (ready_out !== 1'b1 && i < 400) begin
            @(negedge mclk_in);
            i++;
        end
        if (i == 400) fail("host never ready");
    endtask
    task automatic xfer(input logic [7:0] b, input logic rd, input logic last, input int p);
        int i;
        wait_ready();
        req_in = 1'b1;
        req_byte_in = b;
        req_read_in = rd;
        req_last_in = last;
        @(negedge mclk_in);
        req_in = 1'b0;
        i = 0;
        while (done_out !== 1'b1 && i < lat(w_exp) + 60) begin
            @(negedge mclk_in);
            i++;
            if (i == p) pause_in = 1'b1;
            if (i == p + 30) pause_in = 1'b0;
        end
        pause_in = 1'b0;
        if (p == 0 || w_exp == WIDTH_QUAD) cmp_count(i, lat(w_exp));
        else cmp_count(int'(i > lat(w_exp) && done_out === 1'b1), 1);
    endtask
    task automatic session(input logic [7:0] d, input int p);
        logic [7:0] c;
        logic [7:0] t;
        c = safe(8'($random(seed)));
        t = 8'($random(seed));
        rxq.delete();
        xfer(c, 1'b0, 1'b0, 0);
        tx_byte_in = t;
        tx_load_in = 1'b1;
        @(negedge mclk_in);
        tx_load_in = 1'b0;
        respond_in = 1'b1;
        xfer(d, 1'b0, 1'b1, p);
        @(negedge mclk_in);
        cmp_byte(cmd_out, c);
        cmp_byte(rxq.size() > 0 ? rxq[$] : ~d, d);
        xfer(safe(8'($random(seed))), 1'b0, 1'b0, 0);
        respond_in = 1'b0;
        xfer(8'h00, 1'b1, 1'b1, p);
        cmp_byte(h_rx, t);
        cmp_width(d_width, w_exp);
    endtask
    task automatic mode(input logic [7:0] cmd);
        xfer(cmd, 1'b0, 1'b1, 0);
        w_exp = nxt(w_exp, cmd);
        repeat (8) @(negedge mclk_in);
        cmp_width(d_width, w_exp);
        cmp_width(h_width, w_exp);
    endtask

    initial begin
        repeat (6) @(posedge mclk_in);
        @(negedge mclk_in);
        host_rst_n = 1'b1;
        dev_rst_n = 1'b1;
        wait_ready();
        cmp_width(d_width, WIDTH_SINGLE);
        cmp_width(h_width, WIDTH_SINGLE);
        session(8'h3b, 5);
        foreach (cmds[k]) begin
            mode(cmds[k]);
            session(8'($random(seed)), 3 + int'($unsigned($random(seed)) % 15));
        end
        for (int k = 0; k < 2; k++) begin
            mode(k == 0 ? 8'h3b : 8'h38);
            host_rst_n = 1'b0;
            repeat (3) @(negedge mclk_in);
            host_rst_n = 1'b1;
            w_exp = WIDTH_SINGLE;
            wait_ready();
            cmp_width(d_width, WIDTH_SINGLE);
            cmp_width(h_width, WIDTH_SINGLE);
            session(8'($random(seed)), 4);
        end
        conclude();
    end
    initial begin
        #400000;
        fail("timeout");
        conclude();
    end
endmodule
`default_nettype wire
